// ---- rtl/frs_pkg.sv ----
// constants and types for the floppy result-status and command block
// Behaviour
// - Rate register is write-only, survives soft reset, hard reset selects 250 kb/s.
// - Active rate follows whichever of rate or alternate rate register was last written.
// - Two low bits pick the rate, reset to 10; upper bits written as zero.
// - Code 11/00/01/10 gives 1M/500k/300k/250k in MFM; illegal/250k/150k/125k in FM.
// - Alternate mode: bit 2 stored without effect, readable, survives soft reset.
// - Status bytes leave the data port only in a result phase; 1 means active.
// - First byte top bits: 00 normal, 01 abnormal, 10 invalid, 11 ready change.
// - First byte bit 5 on positioning end, bit 4 on track-zero failure, bit 3 zero.
// - First byte carries head select pin and drive number at execution end.
// - Second byte bit 7 when last sector ends without terminal count.
// - Second byte bit 5 is CRC error; third byte bit 5 tells data field.
// - Second byte flags host servicing too late: overrun or underrun.
// - Second byte bit 2 when sector, clean address field or start sector missing.
// - Second byte bit 1 when write protect active as format is issued.
// - Second byte bit 0 missing mark; third byte bit 0 tells data mark.
// - Third byte bit 6 on deleted mark in read/scan, normal mark in read deleted.
// - Third byte bits 5 and 0 also set second byte bits 5 and 0.
// - Sector missing with other recorded track sets bit 4; track FF also bit 1.
// - Scan sets third byte bit 3 on equal, bit 2 when nothing satisfies.
// - Fourth byte: protect, track zero, head, drive; bits 5,3 one, bit 7 zero.
// - Opcode sets byte count; unknown opcode gives result byte 80 hex at once.
// - Configure takes three bytes, loads settings, returns nothing.
// - Format takes ID bytes in execution, returns three status bytes plus one.
// - Dump returns tracks, timing, sector count, lock/perp, config, precomp track.
package frs_pkg;
	localparam logic [1:0] RATE_RST = 2'h2;
	localparam logic [1:0] RATE_1M = 2'h3;
	localparam logic [1:0] RATE_500K = 2'h0;
	localparam logic [1:0] RATE_300K = 2'h1;
	localparam int RATE_LO_BIT = 0;
	localparam int PRECOMP_BIT = 2;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] PRECOMP_START_TRACK_RST = 8'h00;
	localparam logic [7:0] ST_INVALID = 8'h80;
	localparam logic [7:0] TRACK_BAD = 8'hFF;
	localparam logic [7:0] UNDEF_BYTE = 8'h00;
	localparam logic [1:0] IC_NORMAL = 2'h0;
	localparam logic [1:0] IC_ABNORMAL = 2'h1;
	localparam logic [1:0] IC_READY = 2'h3;
	localparam logic [7:0] OP_CONFIGURE = 8'h13;
	localparam logic [7:0] OP_DUMPREG = 8'h0E;
	localparam logic [7:0] OP_FORMAT = 8'h0D;
	localparam logic [7:0] OP_LOCK = 8'h14;
	localparam logic [7:0] OP_MODE = 8'h01;
	localparam logic [7:0] OP_PERP = 8'h12;
	localparam logic [7:0] OP_READ = 8'h06;
	localparam logic [7:0] OP_READ_DEL = 8'h0C;
	localparam logic [7:0] OP_READ_ID = 8'h0A;
	localparam logic [7:0] OP_READ_TRK = 8'h02;
	localparam logic [7:0] OP_RECAL = 8'h07;
	localparam logic [7:0] OP_REL_SEEK = 8'h8F;
	localparam logic [7:0] OP_SCAN_EQ = 8'h11;
	localparam logic [7:0] OP_SCAN_HI = 8'h1D;
	localparam logic [7:0] OP_DRV_STAT = 8'h04;
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_MFM = 8'hBF;
	localparam logic [7:0] MASK_MT = 8'h1F;
	localparam logic [7:0] MASK_LOCK = 8'h7F;
	localparam logic [7:0] MASK_REL = 8'hBF;
	localparam logic [3:0] LEN_RW = 4'h9;
	localparam logic [3:0] LEN_FMT = 4'h6;
	localparam logic [3:0] LEN_CFG = 4'h4;
	localparam logic [3:0] LEN_MODE = 4'h5;
	localparam logic [3:0] LEN_REL = 4'h3;
	localparam logic [3:0] LEN_TWO = 4'h2;
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [3:0] RES_RW = 4'h7;
	localparam logic [3:0] RES_FMT = 4'h4;
	localparam logic [3:0] RES_DUMP = 4'hA;
	localparam logic [3:0] RES_ONE = 4'h1;
	localparam logic [3:0] RES_NONE = 4'h0;
	localparam int PRM_HDDS = 0;
	localparam int PRM_TRACK = 1;
	localparam int PRM_CFG = 1;
	localparam int PRM_PRECOMP_START_TRACK = 2;
	localparam int PRM_SPT = 2;
	localparam int PRM_EOT = 5;
	typedef enum logic [1:0] {FRS_IDLE, FRS_CMD, FRS_EXEC, FRS_RES} frs_state_t;
	typedef enum logic [3:0] {
		K_INV, K_CFG, K_DUMP, K_FMT, K_LOCK, K_MODE, K_PERP,
		K_RW, K_RDDEL, K_SCAN, K_POS, K_DSTAT
	} frs_kind_t;
endpackage : frs_pkg

// ---- rtl/frs_core.sv ----
// rate control register, result status bytes and command sequencing
`timescale 1ns/100ps
module frs_core (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic soft_reset_i,
	input wire logic alt_mode_i,
	input wire logic fm_mode_i,
	input wire logic rate_wr_i,
	input wire logic [7:0] rate_wdata_i,
	input wire logic alt_rate_wr_i,
	input wire logic [1:0] alt_rate_i,
	input wire logic data_wr_i,
	input wire logic [7:0] data_wdata_i,
	input wire logic data_rd_i,
	input wire logic wp_pin_i,
	input wire logic track_zero_pin_i,
	input wire logic head_select_pin_i,
	input wire logic terminal_count_pin_i,
	input wire logic exec_done_i,
	input wire logic ev_abnormal_i,
	input wire logic ev_ready_change_i,
	input wire logic ev_seek_end_i,
	input wire logic ev_track0_fail_i,
	input wire logic ev_last_byte_i,
	input wire logic ev_crc_addr_i,
	input wire logic ev_crc_data_i,
	input wire logic ev_overrun_i,
	input wire logic ev_no_sector_i,
	input wire logic [7:0] recorded_track_i,
	input wire logic ev_no_addr_mark_i,
	input wire logic ev_no_data_mark_i,
	input wire logic ev_deleted_mark_i,
	input wire logic ev_normal_mark_i,
	input wire logic ev_scan_equal_i,
	input wire logic ev_scan_unmet_i,
	input wire logic [31:0] result_id_i,
	input wire logic [31:0] drive_tracks_i,
	input wire logic [15:0] timing_bytes_i,
	output logic [1:0] rate_code_o,
	output logic [9:0] rate_kbps_o,
	output logic rate_illegal_o,
	output logic precomp_off_bit_o,
	output logic [7:0] config_o,
	output logic [7:0] precomp_start_track_o,
	output logic [31:0] mode_o,
	output logic [7:0] perp_o,
	output logic lock_o,
	output logic exec_start_o,
	output logic [7:0] exec_opcode_o,
	output logic [71:0] exec_params_o,
	output logic cmd_ready_o,
	output logic result_valid_o,
	output logic [7:0] data_rdata_o
);
	typedef struct packed {
		frs_pkg::frs_state_t st;
		frs_pkg::frs_kind_t kind;
		logic [1:0] rate;
		logic precomp_off_bit;
		logic [7:0] cfg;
		logic [7:0] precomp_start_track;
		logic lock;
		logic [31:0] mode;
		logic [7:0] perp;
		logic [7:0] opc;
		logic [8:0][7:0] prm;
		logic [3:0] idx;
		logic [3:0] len;
		logic [7:0] st0;
		logic [7:0] st1;
		logic [7:0] st2;
		logic [7:0] st3;
		logic [7:0] eot;
		logic start;
		logic [7:0] rdata;
	} frs_regs_t;

	frs_regs_t s_r;
	frs_regs_t s_nxt;

	function automatic logic hit(input logic [7:0] op, input logic [7:0] code,
		input logic [7:0] mask);
		return (op & mask) == code;
	endfunction : hit

	// command length and class from the opcode
	function automatic logic [7:0] decode(input logic [7:0] op);
		logic [7:0] r;
		r = {frs_pkg::K_INV, frs_pkg::LEN_ONE};
		if (hit(op, frs_pkg::OP_CONFIGURE, frs_pkg::MASK_ALL)) begin
			r = {frs_pkg::K_CFG, frs_pkg::LEN_CFG};
		end else if (hit(op, frs_pkg::OP_DUMPREG, frs_pkg::MASK_ALL)) begin
			r = {frs_pkg::K_DUMP, frs_pkg::LEN_ONE};
		end else if (hit(op, frs_pkg::OP_FORMAT, frs_pkg::MASK_MFM)) begin
			r = {frs_pkg::K_FMT, frs_pkg::LEN_FMT};
		end else if (hit(op, frs_pkg::OP_LOCK, frs_pkg::MASK_LOCK)) begin
			r = {frs_pkg::K_LOCK, frs_pkg::LEN_ONE};
		end else if (hit(op, frs_pkg::OP_MODE, frs_pkg::MASK_ALL)) begin
			r = {frs_pkg::K_MODE, frs_pkg::LEN_MODE};
		end else if (hit(op, frs_pkg::OP_PERP, frs_pkg::MASK_ALL)) begin
			r = {frs_pkg::K_PERP, frs_pkg::LEN_TWO};
		end else if (hit(op, frs_pkg::OP_READ, frs_pkg::MASK_MT)
			|| hit(op, frs_pkg::OP_READ_TRK, frs_pkg::MASK_MFM)) begin
			r = {frs_pkg::K_RW, frs_pkg::LEN_RW};
		end else if (hit(op, frs_pkg::OP_READ_DEL, frs_pkg::MASK_MT)) begin
			r = {frs_pkg::K_RDDEL, frs_pkg::LEN_RW};
		end else if (hit(op, frs_pkg::OP_READ_ID, frs_pkg::MASK_MFM)) begin
			r = {frs_pkg::K_RW, frs_pkg::LEN_TWO};
		end else if (hit(op, frs_pkg::OP_SCAN_EQ, frs_pkg::MASK_MT)
			|| hit(op, frs_pkg::OP_SCAN_HI, frs_pkg::MASK_MT)) begin
			r = {frs_pkg::K_SCAN, frs_pkg::LEN_RW};
		end else if (hit(op, frs_pkg::OP_RECAL, frs_pkg::MASK_ALL)) begin
			r = {frs_pkg::K_POS, frs_pkg::LEN_TWO};
		end else if (hit(op, frs_pkg::OP_REL_SEEK, frs_pkg::MASK_REL)) begin
			r = {frs_pkg::K_POS, frs_pkg::LEN_REL};
		end else if (hit(op, frs_pkg::OP_DRV_STAT, frs_pkg::MASK_ALL)) begin
			r = {frs_pkg::K_DSTAT, frs_pkg::LEN_TWO};
		end
		return r;
	endfunction : decode

	function automatic logic [3:0] res_count(input frs_pkg::frs_kind_t k);
		logic [3:0] c;
		c = frs_pkg::RES_NONE;
		unique case (k)
			frs_pkg::K_INV, frs_pkg::K_LOCK, frs_pkg::K_DSTAT: c = frs_pkg::RES_ONE;
			frs_pkg::K_DUMP: c = frs_pkg::RES_DUMP;
			frs_pkg::K_FMT: c = frs_pkg::RES_FMT;
			frs_pkg::K_RW, frs_pkg::K_RDDEL, frs_pkg::K_SCAN: c = frs_pkg::RES_RW;
			frs_pkg::K_CFG, frs_pkg::K_MODE, frs_pkg::K_PERP, frs_pkg::K_POS: begin
				c = frs_pkg::RES_NONE;
			end
		endcase
		return c;
	endfunction : res_count

	logic [7:0] dec;
	logic cmd_done;
	logic [7:0] rbyte;

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		dec = decode(data_wdata_i);
		cmd_done = 1'b0;
		// last write wins; rate register write wins over alternate rate write if both land at once
		if (alt_rate_wr_i) begin
			s_nxt.rate = alt_rate_i;
		end
		if (rate_wr_i) begin
			s_nxt.rate = rate_wdata_i[frs_pkg::RATE_LO_BIT +: 2];
			if (alt_mode_i) begin
				s_nxt.precomp_off_bit = rate_wdata_i[frs_pkg::PRECOMP_BIT];
			end
		end
		unique case (s_r.st)
			frs_pkg::FRS_IDLE: begin
				if (data_wr_i) begin
					s_nxt.opc = data_wdata_i;
					s_nxt.kind = frs_pkg::frs_kind_t'(dec[7:4]);
					s_nxt.len = dec[3:0];
					s_nxt.idx = 4'h1;
					s_nxt.prm = '0;
					cmd_done = dec[3:0] == frs_pkg::LEN_ONE;
					if (dec[3:0] != frs_pkg::LEN_ONE) begin
						s_nxt.st = frs_pkg::FRS_CMD;
					end
				end
			end
			frs_pkg::FRS_CMD: begin
				if (data_wr_i) begin
					s_nxt.prm[s_r.idx - 4'h1] = data_wdata_i;
					s_nxt.idx = s_r.idx + 4'h1;
					cmd_done = s_nxt.idx == s_r.len;
				end
			end
			frs_pkg::FRS_EXEC: begin
				// error flags are sticky for the whole execution
				if (terminal_count_pin_i == 1'b0 && ev_last_byte_i) begin
					s_nxt.st1[7] = 1'b1;
				end
				if (ev_crc_addr_i) begin
					s_nxt.st1[5] = 1'b1;
				end
				if (ev_crc_data_i) begin
					s_nxt.st1[5] = 1'b1;
					s_nxt.st2[5] = 1'b1;
				end
				if (ev_overrun_i) begin
					s_nxt.st1[4] = 1'b1;
				end
				if (ev_no_sector_i) begin
					s_nxt.st1[2] = 1'b1;
					if (recorded_track_i != s_r.prm[frs_pkg::PRM_TRACK]) begin
						s_nxt.st2[4] = 1'b1;
						s_nxt.st2[1] = s_nxt.st2[1]
							| (recorded_track_i == frs_pkg::TRACK_BAD);
					end
				end
				if (ev_no_addr_mark_i) begin
					s_nxt.st1[0] = 1'b1;
				end
				if (ev_no_data_mark_i) begin
					s_nxt.st1[0] = 1'b1;
					s_nxt.st2[0] = 1'b1;
				end
				if ((ev_deleted_mark_i && s_r.kind != frs_pkg::K_RDDEL)
					|| (ev_normal_mark_i && s_r.kind == frs_pkg::K_RDDEL)) begin
					s_nxt.st2[6] = 1'b1;
				end
				if (s_r.kind == frs_pkg::K_SCAN) begin
					s_nxt.st2[3] = s_nxt.st2[3] | ev_scan_equal_i;
					s_nxt.st2[2] = s_nxt.st2[2] | ev_scan_unmet_i;
				end
				if (ev_abnormal_i) begin
					s_nxt.st0[7:6] = frs_pkg::IC_ABNORMAL;
				end
				if (ev_ready_change_i) begin
					s_nxt.st0[7:6] = frs_pkg::IC_READY;
				end
				if (ev_seek_end_i) begin
					s_nxt.st0[5] = 1'b1;
				end
				if (ev_track0_fail_i) begin
					s_nxt.st0[4] = 1'b1;
				end
				if (exec_done_i) begin
					s_nxt.st0[3] = 1'b0;
					s_nxt.st0[2] = head_select_pin_i;
					s_nxt.st0[1:0] = s_r.prm[frs_pkg::PRM_HDDS][1:0];
					s_nxt.idx = 4'h0;
					s_nxt.len = res_count(s_r.kind);
					s_nxt.st = (s_nxt.len == frs_pkg::RES_NONE) ? frs_pkg::FRS_IDLE
						: frs_pkg::FRS_RES;
				end
			end
			frs_pkg::FRS_RES: begin
				if (data_rd_i) begin
					s_nxt.idx = s_r.idx + 4'h1;
					if (s_nxt.idx == s_r.len) begin
						s_nxt.st = frs_pkg::FRS_IDLE;
					end
				end
			end
		endcase
		if (cmd_done) begin
			s_nxt.idx = 4'h0;
			s_nxt.len = res_count(s_nxt.kind);
			s_nxt.st = (s_nxt.len == frs_pkg::RES_NONE) ? frs_pkg::FRS_IDLE
				: frs_pkg::FRS_RES;
			unique case (s_nxt.kind)
				frs_pkg::K_INV: s_nxt.st0 = frs_pkg::ST_INVALID;
				frs_pkg::K_CFG: begin
					s_nxt.cfg = s_nxt.prm[frs_pkg::PRM_CFG];
					s_nxt.precomp_start_track = s_nxt.prm[frs_pkg::PRM_PRECOMP_START_TRACK];
				end
				frs_pkg::K_MODE: s_nxt.mode = {s_nxt.prm[0], s_nxt.prm[1], s_nxt.prm[2],
					s_nxt.prm[3]};
				frs_pkg::K_PERP: s_nxt.perp = s_nxt.prm[0];
				frs_pkg::K_LOCK: s_nxt.lock = s_nxt.opc[7];
				frs_pkg::K_DUMP: begin
				end
				frs_pkg::K_DSTAT: begin
					s_nxt.st3 = {1'b0, wp_pin_i, 1'b1, track_zero_pin_i, 1'b1,
						s_nxt.prm[frs_pkg::PRM_HDDS][2:0]};
				end
				frs_pkg::K_FMT, frs_pkg::K_RW, frs_pkg::K_RDDEL, frs_pkg::K_SCAN,
				frs_pkg::K_POS: begin
					s_nxt.st = frs_pkg::FRS_EXEC;
					s_nxt.start = 1'b1;
					s_nxt.st0 = {frs_pkg::IC_NORMAL, 6'h00};
					s_nxt.st1 = 8'h00;
					s_nxt.st2 = 8'h00;
					if (s_nxt.kind == frs_pkg::K_FMT) begin
						s_nxt.st1[1] = wp_pin_i;
						s_nxt.eot = s_nxt.prm[frs_pkg::PRM_SPT];
					end else if (s_nxt.len == frs_pkg::RES_RW
						&& s_nxt.opc[3:0] != frs_pkg::OP_READ_ID[3:0]) begin
						s_nxt.eot = s_nxt.prm[frs_pkg::PRM_EOT];
					end
				end
			endcase
		end
		if (soft_reset_i) begin
			// rate code, precomp bit, mode and perp stay; configure settings stay only while locked
			s_nxt.st = frs_pkg::FRS_IDLE;
			s_nxt.idx = 4'h0;
			s_nxt.start = 1'b0;
			if (!s_r.lock) begin
				s_nxt.cfg = frs_pkg::CFG_RST;
				s_nxt.precomp_start_track = frs_pkg::PRECOMP_START_TRACK_RST;
			end
		end
		// preload the byte the host will read next
		rbyte = 8'h00;
		if (s_nxt.st == frs_pkg::FRS_RES) begin
			unique case (s_nxt.kind)
				frs_pkg::K_INV: rbyte = s_nxt.st0;
				frs_pkg::K_LOCK: rbyte = {3'h0, s_nxt.lock, 4'h0};
				frs_pkg::K_DSTAT: rbyte = s_nxt.st3;
				frs_pkg::K_DUMP: begin
					unique case (s_nxt.idx)
						4'h0, 4'h1, 4'h2, 4'h3: rbyte = drive_tracks_i[s_nxt.idx[1:0] * 8 +: 8];
						4'h4: rbyte = timing_bytes_i[15:8];
						4'h5: rbyte = timing_bytes_i[7:0];
						4'h6: rbyte = s_nxt.eot;
						4'h7: rbyte = {s_nxt.lock, 1'b0, s_nxt.perp[5:0]};
						4'h8: rbyte = s_nxt.cfg;
						default: rbyte = s_nxt.precomp_start_track;
					endcase
				end
				default: begin
					unique case (s_nxt.idx)
						4'h0: rbyte = s_nxt.st0;
						4'h1: rbyte = s_nxt.st1;
						4'h2: rbyte = s_nxt.st2;
						default: begin
							rbyte = (s_nxt.kind == frs_pkg::K_FMT) ? frs_pkg::UNDEF_BYTE
								: result_id_i[(4'h6 - s_nxt.idx) * 8 +: 8];
						end
					endcase
				end
			endcase
		end
		s_nxt.rdata = rbyte;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r <= '0;
			s_r.st <= frs_pkg::FRS_IDLE;
			s_r.kind <= frs_pkg::K_INV;
			s_r.rate <= frs_pkg::RATE_RST;
			s_r.cfg <= frs_pkg::CFG_RST;
			s_r.precomp_start_track <= frs_pkg::PRECOMP_START_TRACK_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// data rate in kb/s; zero marks the FM code that has no rate
	always_comb begin
		unique case (s_r.rate)
			frs_pkg::RATE_1M: rate_kbps_o = fm_mode_i ? 10'h000 : 10'h3E8;
			frs_pkg::RATE_500K: rate_kbps_o = fm_mode_i ? 10'h0FA : 10'h1F4;
			frs_pkg::RATE_300K: rate_kbps_o = fm_mode_i ? 10'h096 : 10'h12C;
			default: rate_kbps_o = fm_mode_i ? 10'h07D : 10'h0FA;
		endcase
	end

	assign rate_illegal_o = fm_mode_i && s_r.rate == frs_pkg::RATE_1M;
	assign rate_code_o = s_r.rate;
	assign precomp_off_bit_o = s_r.precomp_off_bit;
	assign config_o = s_r.cfg;
	assign precomp_start_track_o = s_r.precomp_start_track;
	assign mode_o = s_r.mode;
	assign perp_o = s_r.perp;
	assign lock_o = s_r.lock;
	assign exec_start_o = s_r.start;
	assign exec_opcode_o = s_r.opc;
	assign exec_params_o = s_r.prm;
	assign cmd_ready_o = s_r.st == frs_pkg::FRS_IDLE || s_r.st == frs_pkg::FRS_CMD;
	assign result_valid_o = s_r.st == frs_pkg::FRS_RES;
	assign data_rdata_o = s_r.rdata;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	a_rate_write: assert property (rate_wr_i && !soft_reset_i |=>
		rate_code_o == $past(rate_wdata_i[1:0]))
		else $error("rate code does not follow last rate write");
	a_rate_alt: assert property (alt_rate_wr_i && !rate_wr_i |=>
		rate_code_o == $past(alt_rate_i))
		else $error("rate code does not follow alternate rate write");
	a_rate_softkeep: assert property (soft_reset_i && !rate_wr_i && !alt_rate_wr_i
		|=> $stable(rate_code_o) && $stable(precomp_off_bit_o))
		else $error("soft reset changed rate register");
	a_rate_fm: assert property (fm_mode_i && rate_code_o == 2'h1 |->
		rate_kbps_o == 10'h096 && !rate_illegal_o)
		else $error("wrong fm rate for code 01");
	a_invalid_op: assert property (cmd_ready_o && s_r.st == frs_pkg::FRS_IDLE && data_wr_i
		&& decode(data_wdata_i) == {frs_pkg::K_INV, frs_pkg::LEN_ONE} && !soft_reset_i
		|=> result_valid_o && data_rdata_o == 8'h80)
		else $error("invalid opcode not answered with 80");
	a_result_gate: assert property (!result_valid_o |-> data_rdata_o == 8'h00)
		else $error("data port shows status outside result phase");
	a_st0_bit3: assert property (result_valid_o && s_r.kind != frs_pkg::K_DUMP
		&& s_r.kind != frs_pkg::K_DSTAT && s_r.idx == 4'h0 |-> !data_rdata_o[3])
		else $error("first status byte bit 3 set");
	a_st3_fixed: assert property (result_valid_o && s_r.kind == frs_pkg::K_DSTAT
		|-> data_rdata_o[7:5] == {1'b0, data_rdata_o[6], 1'b1} && data_rdata_o[3])
		else $error("drive status fixed bits wrong");
	a_crc_pair: assert property (s_r.st == frs_pkg::FRS_EXEC && ev_crc_data_i
		&& !soft_reset_i |=> s_r.st1[5] && s_r.st2[5])
		else $error("data crc not in both status bytes");
	a_end_track: assert property (s_r.st == frs_pkg::FRS_EXEC && ev_last_byte_i
		&& terminal_count_pin_i |=> s_r.st1[7] == $past(s_r.st1[7]))
		else $error("end of track set despite terminal count");
	a_cfg_noresult: assert property (s_r.st == frs_pkg::FRS_CMD && s_r.kind == frs_pkg::K_CFG
		&& data_wr_i && s_r.idx == 4'h3 && !soft_reset_i
		|=> !result_valid_o && config_o == $past(s_r.prm[1])
		&& precomp_start_track_o == $past(data_wdata_i))
		else $error("configure not applied");
	c_invalid: cover property (s_r.st == frs_pkg::FRS_RES && s_r.kind == frs_pkg::K_INV);
	c_format_end: cover property (s_r.kind == frs_pkg::K_FMT && s_r.st == frs_pkg::FRS_RES
		&& s_r.idx == 4'h3);
	c_dump_end: cover property (s_r.kind == frs_pkg::K_DUMP && s_r.idx == 4'h9);
	c_soft_keep: cover property (soft_reset_i && rate_code_o == frs_pkg::RATE_1M);

endmodule : frs_core

// ---- tb/frs_exec_model.sv ----
// execution engine stand-in that finishes each handed-off command
`timescale 1ns/100ps
module frs_exec_model #(
	parameter int LAT = 4
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic exec_start_i,
	output logic exec_done_o
);
	logic [3:0] cnt_r;
	// fixed latency stands in for stepping and the whole-track format pass
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= 4'h0;
			exec_done_o <= 1'b0;
		end else begin
			exec_done_o <= (cnt_r == 4'h1);
			if (exec_start_i) begin
				cnt_r <= LAT[3:0];
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule : frs_exec_model

// ---- tb/tb_floppy_result_status_cmd.sv ----
// self-checking bench for the floppy result-status and command block
`timescale 1ns/100ps
module tb_floppy_result_status_cmd;
	logic mclk_i, arst_n_i, soft_reset_i, alt_mode_i, fm_mode_i, rate_wr_i, alt_rate_wr_i;
	logic data_wr_i, data_rd_i, wp_pin_i, track_zero_pin_i, head_select_pin_i;
	logic terminal_count_pin_i, exec_done_i, ev_abnormal_i, ev_ready_change_i, ev_seek_end_i;
	logic ev_track0_fail_i, ev_last_byte_i, ev_crc_addr_i, ev_crc_data_i, ev_overrun_i;
	logic ev_no_sector_i, ev_no_addr_mark_i, ev_no_data_mark_i, ev_deleted_mark_i;
	logic ev_normal_mark_i, ev_scan_equal_i, ev_scan_unmet_i;
	logic rate_illegal_o, precomp_off_bit_o, lock_o, exec_start_o, cmd_ready_o, result_valid_o;
	logic [1:0] alt_rate_i, rate_code_o;
	logic [7:0] rate_wdata_i, data_wdata_i, recorded_track_i, config_o, precomp_start_track_o;
	logic [7:0] exec_opcode_o, perp_o, data_rdata_o;
	logic [31:0] result_id_i, drive_tracks_i, mode_o;
	logic [15:0] timing_bytes_i;
	logic [9:0] rate_kbps_o;
	logic [71:0] exec_params_o;
	int err_total = 0;
	int compares = 0;
	frs_core frs_core_i (.mclk_i, .arst_n_i, .soft_reset_i, .alt_mode_i, .fm_mode_i,
		.rate_wr_i, .rate_wdata_i, .alt_rate_wr_i, .alt_rate_i, .data_wr_i, .data_wdata_i,
		.data_rd_i, .wp_pin_i, .track_zero_pin_i, .head_select_pin_i, .terminal_count_pin_i,
		.exec_done_i, .ev_abnormal_i, .ev_ready_change_i, .ev_seek_end_i, .ev_track0_fail_i,
		.ev_last_byte_i, .ev_crc_addr_i, .ev_crc_data_i, .ev_overrun_i, .ev_no_sector_i,
		.recorded_track_i, .ev_no_addr_mark_i, .ev_no_data_mark_i, .ev_deleted_mark_i,
		.ev_normal_mark_i, .ev_scan_equal_i, .ev_scan_unmet_i, .result_id_i, .drive_tracks_i,
		.timing_bytes_i, .rate_code_o, .rate_kbps_o, .rate_illegal_o, .precomp_off_bit_o,
		.config_o, .precomp_start_track_o, .mode_o, .perp_o, .lock_o, .exec_start_o,
		.exec_opcode_o, .exec_params_o, .cmd_ready_o, .result_valid_o, .data_rdata_o);
	frs_exec_model frs_exec_model_i (.mclk_i, .arst_n_i, .exec_start_i(exec_start_o),
		.exec_done_o(exec_done_i));
	always #20 mclk_i = ~mclk_i;
	task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] b);
		@(posedge mclk_i);
		data_wr_i <= 1'b1;
		data_wdata_i <= b;
		@(posedge mclk_i);
		data_wr_i <= 1'b0;
	endtask : wr
	// waits a bounded span for the result phase, then checks and pops one byte
	task automatic rd(input string nm, input logic [7:0] exp);
		for (int i = 0; i < 30 && result_valid_o !== 1'b1; i++) @(posedge mclk_i);
		#1;
		chk({nm, " phase"}, 10'h001, {9'h000, result_valid_o});
		chk(nm, {2'h0, exp}, {2'h0, data_rdata_o});
		@(posedge mclk_i);
		data_rd_i <= 1'b1;
		@(posedge mclk_i);
		data_rd_i <= 1'b0;
	endtask : rd
	task automatic rate_wr(input logic [7:0] d, input logic fm, input logic alt);
		@(posedge mclk_i);
		rate_wr_i <= 1'b1;
		rate_wdata_i <= d;
		fm_mode_i <= fm;
		alt_mode_i <= alt;
		@(posedge mclk_i);
		rate_wr_i <= 1'b0;
		#1;
	endtask : rate_wr
	task automatic t_rate();
		logic [9:0] kb [8] = '{10'h1F4, 10'h12C, 10'h0FA, 10'h3E8,
			10'h0FA, 10'h096, 10'h07D, 10'h000};
		chk("rate reset", 10'h002, {8'h00, rate_code_o});
		for (int f = 0; f < 2; f++) begin
			for (int c = 0; c < 4; c++) begin
				rate_wr(8'hFC | 8'(c), f[0], 1'b0);
				chk("rate code", 10'(c), {8'h00, rate_code_o});
				chk("rate kbps", kb[f * 4 + c], rate_kbps_o);
				chk("rate illegal", {9'h000, f == 1 && c == 3}, {9'h000, rate_illegal_o});
				chk("precomp", 10'h000, {9'h000, precomp_off_bit_o});
			end
		end
		@(posedge mclk_i);
		alt_rate_i <= 2'h1;
		alt_rate_wr_i <= 1'b1;
		@(posedge mclk_i);
		alt_rate_wr_i <= 1'b0;
		#1;
		chk("alt rate", 10'h001, {8'h00, rate_code_o});
		rate_wr(8'h04, 1'b0, 1'b1);
		chk("last write", 10'h000, {8'h00, rate_code_o});
		chk("precomp alt", 10'h001, {9'h000, precomp_off_bit_o});
		@(posedge mclk_i);
		soft_reset_i <= 1'b1;
		@(posedge mclk_i);
		soft_reset_i <= 1'b0;
		#1;
		chk("soft rate", 10'h000, {8'h00, rate_code_o});
		chk("soft precomp", 10'h001, {9'h000, precomp_off_bit_o});
		@(posedge mclk_i);
		arst_n_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk("hard rate", 10'h002, {8'h00, rate_code_o});
		chk("hard precomp", 10'h000, {9'h000, precomp_off_bit_o});
		@(posedge mclk_i);
		arst_n_i <= 1'b1;
		$display("rate test done");
	endtask : t_rate
	logic [7:0] fmt [6] = '{8'h0D, 8'h02, 8'h02, 8'h09, 8'h1B, 8'hE5};
	logic [7:0] rdc [9] = '{8'h06, 8'h01, 8'h05, 8'h00, 8'h01, 8'h02, 8'h12, 8'h1B, 8'hFF};
	task automatic t_cmds();
		wr(8'hFF);
		rd("invalid", 8'h80);
		#1;
		chk("idle after", 10'h001, {9'h000, cmd_ready_o});
		wr(8'h13);
		wr(8'h00);
		wr(8'h5A);
		wr(8'h21);
		#1;
		chk("config", 10'h05A, {2'h0, config_o});
		chk("precomp_start_track", 10'h021, {2'h0, precomp_start_track_o});
		chk("no result", 10'h000, {9'h000, result_valid_o});
		wp_pin_i <= 1'b1;
		head_select_pin_i <= 1'b1;
		foreach (fmt[i]) wr(fmt[i]);
		rd("fmt st0", 8'h06);
		rd("fmt st1", 8'h02);
		rd("fmt st2", 8'h00);
		rd("fmt undef", 8'h00);
		chk("fmt opcode", 10'h00D, {2'h0, exec_opcode_o});
		$display("command test done");
	endtask : t_cmds
	task automatic t_read();
		head_select_pin_i <= 1'b0;
		{ev_abnormal_i, ev_crc_data_i, ev_no_sector_i} <= 3'h7;
		{ev_last_byte_i, terminal_count_pin_i} <= 2'h3;
		recorded_track_i <= 8'hFF;
		result_id_i <= 32'h05000102;
		foreach (rdc[i]) wr(rdc[i]);
		rd("rd st0", 8'h41);
		rd("rd st1", 8'h24);
		rd("rd st2", 8'h32);
		rd("rd trk", 8'h05);
		rd("rd head", 8'h00);
		rd("rd sec", 8'h01);
		rd("rd size", 8'h02);
		{ev_abnormal_i, ev_crc_data_i, ev_no_sector_i} <= 3'h0;
		{ev_last_byte_i, terminal_count_pin_i} <= 2'h0;
		track_zero_pin_i <= 1'b1;
		wr(8'h04);
		wr(8'h06);
		rd("drive st", 8'h7E);
		$display("read test done");
	endtask : t_read
	task automatic t_scan();
		{ev_scan_equal_i, ev_deleted_mark_i, ev_last_byte_i} <= 3'h7;
		{ev_overrun_i, ev_no_data_mark_i} <= 2'h3;
		wr(8'h11);
		for (int i = 1; i < 9; i++) wr(rdc[i]);
		rd("scan st0", 8'h01);
		rd("scan st1", 8'h91);
		rd("scan st2", 8'h49);
		for (int i = 3; i < 7; i++) rd("scan id", result_id_i[(6 - i) * 8 +: 8]);
		{ev_scan_equal_i, ev_deleted_mark_i, ev_last_byte_i} <= 3'h0;
		{ev_overrun_i, ev_no_data_mark_i} <= 2'h0;
		$display("scan test done");
	endtask : t_scan
	task automatic t_dump();
		logic [7:0] dx [10] = '{8'h05, 8'h1A, 8'h2B, 8'h4C, 8'hA1, 8'hB2, 8'h12, 8'h80,
			8'h5A, 8'h21};
		drive_tracks_i <= 32'h4C2B1A05;
		timing_bytes_i <= 16'hA1B2;
		wr(8'h94);
		rd("lock", 8'h10);
		chk("lock bit", 10'h001, {9'h000, lock_o});
		wr(8'h0E);
		foreach (dx[i]) rd("dump", dx[i]);
		#1;
		chk("dump idle", 10'h000, {9'h000, result_valid_o});
		$display("dump test done");
	endtask : t_dump
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		mclk_i = 1'b0;
		arst_n_i = 1'b0;
		{soft_reset_i, alt_mode_i, fm_mode_i, rate_wr_i, alt_rate_wr_i, data_wr_i} = '0;
		{data_rd_i, wp_pin_i, track_zero_pin_i, head_select_pin_i, terminal_count_pin_i} = '0;
		{ev_abnormal_i, ev_ready_change_i, ev_seek_end_i, ev_track0_fail_i, ev_last_byte_i} = '0;
		{ev_crc_addr_i, ev_crc_data_i, ev_overrun_i, ev_no_sector_i, ev_no_addr_mark_i} = '0;
		{ev_no_data_mark_i, ev_deleted_mark_i, ev_normal_mark_i, ev_scan_equal_i} = '0;
		{ev_scan_unmet_i, alt_rate_i, rate_wdata_i, data_wdata_i, recorded_track_i} = '0;
		{result_id_i, drive_tracks_i, timing_bytes_i} = '0;
		repeat (10) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		t_rate();
		t_cmds();
		t_read();
		t_scan();
		t_dump();
		finish_test();
	end
	// whole run is well under two thousand cycles
	initial begin
		#400000;
		err_total++;
		$display("watchdog expired");
		finish_test();
	end
endmodule : tb_floppy_result_status_cmd
